// File: sim/core_model.sv
/* Core stand-in: holds a PC, jumps on calls and returns, pulses returns.
   Assumes pclk and the active-low presetn of the controller. */
`default_nettype none
module core_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Bench control
   input  wire logic        slow,
   input  wire logic        ret_req,
   // Controller side
   input  wire logic        irq_call,
   input  wire logic [12:0] irq_vector,
   input  wire logic        ret_load,
   input  wire logic [12:0] ret_pc,
   output logic      [12:0] core_pc,
   output logic             core_boundary,
   output logic             ret_pop
);
   timeunit 1ns;
   timeprecision 1ps;
   // PC follows vectored calls and returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_pc <= 13'h0100;
      end else if (irq_call) begin
         core_pc <= irq_vector;
      end else if (ret_load) begin
         core_pc <= ret_pc;
      end
   end
   // Boundary each cycle, or every other when slow; one-cycle return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_boundary <= 1'b0;
         ret_pop       <= 1'b0;
      end else begin
         core_boundary <= !slow || !core_boundary;
         ret_pop       <= ret_req && !ret_pop;
      end
   end
endmodule
`default_nettype wire

// File: sim/vectored_interrupt_control_tb_top.sv
/* Self-checking bench for the interrupt controller over APB.
   Assumes the core stand-in and the design sources. */
`default_nettype none
module vectored_interrupt_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err_seen;
   logic touch_evt, protect_evt, uart_evt, eeprom_evt, sif_evt, adc_evt, lowvolt_evt;
   logic pin_in, pin_dir_input, pin_pullup_sel, pin_pullup_en, sleep_mode, call_push;
   logic irq_call, ret_load, stack_full, wake_req, core_boundary, ret_pop, slow, ret_req;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  tm0_evt, tm1_evt;
   logic [1:0]  tb_evt;
   logic [12:0] core_pc, irq_vector, ret_pc;
   int          errors, comparisons, cycles;

   vectored_interrupt_control vectored_interrupt_control_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .touch_evt, .protect_evt, .tm0_evt,
      .tm1_evt, .uart_evt, .eeprom_evt, .sif_evt, .adc_evt, .lowvolt_evt, .tb_evt, .pin_in,
      .pin_dir_input, .pin_pullup_sel, .pin_pullup_en, .core_pc, .core_boundary, .call_push,
      .ret_pop, .sleep_mode, .irq_call, .irq_vector, .ret_load, .ret_pc, .stack_full, .wake_req);
   core_model core_model_inst (.pclk, .presetn, .slow, .ret_req, .irq_call, .irq_vector,
      .ret_load, .ret_pc, .core_pc, .core_boundary, .ret_pop);

   // Clock and hang limit
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, {24'h0, e}, rd);
   endtask

   // One-cycle source events
   task automatic fire(input logic [6:0] s, input logic [3:0] t0, input logic [3:0] t1,
                       input logic [1:0] tb);
      @(posedge pclk);
      {touch_evt, protect_evt, uart_evt, eeprom_evt, sif_evt, adc_evt, lowvolt_evt} <= s;
      tm0_evt <= t0;
      tm1_evt <= t1;
      tb_evt <= tb;
      @(posedge pclk);
      {touch_evt, protect_evt, uart_evt, eeprom_evt, sif_evt, adc_evt, lowvolt_evt} <= 7'h0;
      tm0_evt <= 4'h0;
      tm1_evt <= 4'h0;
      tb_evt <= 2'h0;
   endtask

   function automatic logic sig(input int s);
      return s == 0 ? irq_call : (s == 1 ? ret_load : wake_req);
   endfunction

   task automatic await(input string n, input int s);
      int k;
      k = 0;
      while (sig(s) !== 1'b1 && k < 20) begin
         @(negedge pclk);
         k++;
      end
      chk(n, 32'h1, {31'h0, sig(s)});
   endtask

   task automatic quiet(input string n, input int s);
      logic seen;
      seen = 1'b0;
      repeat (6) begin
         @(negedge pclk);
         seen = seen | sig(s);
      end
      chk(n, 32'h0, {31'h0, seen});
   endtask

   task automatic call_at(input string n, input logic [12:0] v);
      await(n, 0);
      chk(n, {19'h0, v}, {19'h0, irq_vector});
   endtask

   task automatic pop(input int n);
      repeat (n) begin
         @(posedge pclk);
         ret_req <= 1'b1;
         @(posedge pclk);
         ret_req <= 1'b0;
      end
   endtask

   task automatic pin_to(input logic v);
      @(posedge pclk);
      pin_in <= v;
      repeat (2) @(posedge pclk);
   endtask

   task automatic t_reset();
      for (int a = 0; a < 28; a += 4) begin
         rdc("reset value", a[7:0], 8'h00);
      end
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err_seen});
   endtask

   task automatic t_touch();
      wr(8'h00, 8'h05);
      fire(7'h40, 4'h0, 4'h0, 2'h0);
      call_at("touch vector", 13'h0008);
      rdc("core after touch", 8'h00, 8'h04);
      pop(1);
      await("return pulse", 1);
      chk("return pc", 32'h100, {19'h0, ret_pc});
   endtask

   task automatic t_block();
      wr(8'h04, 8'h0f);
      wr(8'h00, 8'h0e);
      fire(7'h7f, 4'hf, 4'h0, 2'h3);
      quiet("call while blocked", 0);
      rdc("core flags", 8'h00, 8'h6e);
      rdc("timer0 flags", 8'h04, 8'hff);
      rdc("serial flags", 8'h08, 8'he0);
      rdc("timebase flags", 8'h0c, 8'hf0);
      wr(8'h04, 8'hf0);
      wr(8'h00, 8'h61);
      quiet("call without enable", 0);
      for (int a = 0; a < 16; a += 4) wr(a[7:0], 8'h00);
   endtask

   task automatic t_prio();
      wr(8'h0c, 8'hff);
      wr(8'h00, 8'h01);
      call_at("lowvolt vector", 13'h0030);
      rdc("timebase after", 8'h0c, 8'hef);
      wr(8'h00, 8'h01);
      call_at("adc vector", 13'h0034);
      wr(8'h0c, 8'h00);
   endtask

   task automatic t_stack();
      for (int i = 0; i < 6; i++) begin
         wr(8'h00, 8'h25);
         await("fill call", 0);
      end
      chk("stack full", 32'h1, {31'h0, stack_full});
      rdc("stack level", 8'h18, 8'h08);
      @(posedge pclk);
      call_push <= 1'b1;
      @(posedge pclk);
      call_push <= 1'b0;
      rdc("push at full", 8'h18, 8'h08);
      wr(8'h00, 8'h25);
      quiet("call when full", 0);
      pop(1);
      await("call after pop", 0);
      pop(4);
   endtask

   task automatic t_pin();
      pin_pullup_sel <= 1'b1;
      wr(8'h14, 8'h03);
      wr(8'h00, 8'h02);
      pin_to(1'b1);
      pin_to(1'b0);
      rdc("pin as port", 8'h00, 8'h02);
      pin_dir_input <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(8'h14, s[7:0]);
         wr(8'h00, 8'h02);
         pin_to(1'b1);
         rdc("rise flag", 8'h00, s[0] ? 8'h12 : 8'h02);
         wr(8'h00, 8'h02);
         pin_to(1'b0);
         rdc("fall flag", 8'h00, s[1] ? 8'h12 : 8'h02);
      end
      wr(8'h00, 8'h13);
      call_at("pin vector", 13'h0004);
      rdc("core after pin", 8'h00, 8'h02);
      chk("pull-up kept", 32'h1, {31'h0, pin_pullup_en});
   endtask

   task automatic t_group();
      slow <= 1'b1;
      wr(8'h10, 8'h08);
      wr(8'h08, 8'h01);
      wr(8'h00, 8'h01);
      fire(7'h00, 4'h0, 4'h8, 2'h0);
      call_at("group vector", 13'h002c);
      rdc("member kept", 8'h10, 8'h88);
      rdc("group cleared", 8'h08, 8'h01);
      wr(8'h10, 8'h00);
   endtask

   task automatic t_wake();
      sleep_mode <= 1'b1;
      fire(7'h02, 4'h0, 4'h0, 2'h0);
      await("wake on new flag", 2);
      fire(7'h02, 4'h0, 4'h0, 2'h0);
      quiet("wake on set flag", 2);
      sleep_mode <= 1'b0;
   endtask

   // Reset, then each scenario in turn
   initial begin
      {presetn, psel, penable, pwrite, pin_in, pin_dir_input, pin_pullup_sel} = 7'h0;
      {touch_evt, protect_evt, uart_evt, eeprom_evt, sif_evt, adc_evt, lowvolt_evt} = 7'h0;
      {sleep_mode, call_push, slow, ret_req, paddr, pwdata} = 44'h0;
      {tm0_evt, tm1_evt, tb_evt} = 10'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_touch();
      t_block();
      t_prio();
      t_stack();
      t_pin();
      t_group();
      t_wake();
      end_sim();
   end
endmodule
`default_nettype wire

// File: src/irq_flag_reg.sv
/*
 * One 8-bit flag/enable register: software write, hardware set, hardware clear.
 * Assumes set and clear are one-cycle strobes on pclk.
 */
`default_nettype none

module irq_flag_reg #(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] RST  = 8'h00
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Software access
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Hardware strobes
   input  wire logic [7:0] set,
   input  wire logic [7:0] clr,
   // Contents
   output logic      [7:0] q
);
   logic [7:0] q_ff;

   // Write, then clear, then set: a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= RST;
      end else begin
         q_ff <= (((we ? wdata : q_ff) & ~clr) | set) & MASK;
      end
   end

   assign q = q_ff;
endmodule

`default_nettype wire

// File: src/pin_edge_detect.sv
/*
 * Edge detector for the external interrupt pin with selectable edge type.
 * Assumes the pin is already synchronous to pclk.
 */
`default_nettype none
`include "vic_defines.svh"

module pin_edge_detect (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Pin and control
   input  wire logic       pin_in,
   input  wire logic       active,
   input  wire logic [1:0] sel,
   // Detected edge, one cycle
   output logic            evt
);
   logic prev_ff;
   logic armed_ff;
   logic rise;
   logic fall;

   // Previous pin level and arming after activation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff  <= pin_in;
         armed_ff <= active;
      end
   end

   // Edge match against the select field
   always_comb begin
      rise = pin_in & ~prev_ff;
      fall = ~pin_in & prev_ff;
      case (sel)
         `VIC_EDGE_RISE: evt = armed_ff & active & rise;
         `VIC_EDGE_FALL: evt = armed_ff & active & fall;
         `VIC_EDGE_BOTH: evt = armed_ff & active & (rise | fall);
         default:        evt = 1'b0;
      endcase
   end
endmodule

`default_nettype wire

// File: src/vectored_interrupt_control.sv
/*
 * Vectored interrupt controller: request flags, enables, priority,
 * vectored call with return stack, group flag, pin edge and wake-up.
 * Assumes an APB master, a core that pulses call_push / ret_pop and
 * marks instruction boundaries, and one-cycle source event pulses.
 */
`default_nettype none
`include "vic_defines.svh"

module vectored_interrupt_control #(
   parameter vic_pkg::variant_t VARIANT = vic_pkg::VAR_FULL,
   parameter int                PC_W    = 13,
   parameter int                DEPTH   = `VIC_STACK_DEPTH
) (
   // APB slave
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Source events, one-cycle pulses
   input  wire logic            touch_evt,
   input  wire logic            protect_evt,
   input  wire logic [3:0]      tm0_evt,
   input  wire logic [3:0]      tm1_evt,
   input  wire logic            uart_evt,
   input  wire logic            eeprom_evt,
   input  wire logic            sif_evt,
   input  wire logic            adc_evt,
   input  wire logic            lowvolt_evt,
   input  wire logic [1:0]      tb_evt,
   // External pin
   input  wire logic            pin_in,
   input  wire logic            pin_dir_input,
   input  wire logic            pin_pullup_sel,
   output logic                 pin_pullup_en,
   // Core sequencer
   input  wire logic [PC_W-1:0] core_pc,
   input  wire logic            core_boundary,
   input  wire logic            call_push,
   input  wire logic            ret_pop,
   input  wire logic            sleep_mode,
   output logic                 irq_call,
   output logic      [PC_W-1:0] irq_vector,
   output logic                 ret_load,
   output logic      [PC_W-1:0] ret_pc,
   output logic                 stack_full,
   output logic                 wake_req
);
   import vic_pkg::*;

   localparam int SPW  = $clog2(DEPTH + 1);
   localparam int IDXW = $clog2(DEPTH);
   localparam int NV   = `VIC_NUM_VEC;
   localparam logic [7:0] SER_MASK =
      (VARIANT == VAR_SMALL) ? `VIC_MASK_SER_SM : `VIC_MASK_ALL;
   localparam logic [7:0] GRP_MASK =
      (VARIANT == VAR_SMALL) ? `VIC_MASK_GRP_SM :
      (VARIANT == VAR_MID)   ? `VIC_MASK_GRP_MID : `VIC_MASK_ALL;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]      core_q, tm0_q, ser_q, tba_q, grp_q;
   logic [7:0]      core_set, tm0_set, ser_set, tba_set, grp_set;
   logic [7:0]      core_clr, tm0_clr, ser_clr, tba_clr;
   logic            we_core, we_tm0, we_ser, we_tba, we_grp;
   logic            wr_en, rd_setup, hit;
   logic [1:0]      edge_ff;
   logic [3:0]      grp_prev_ff;
   logic            group_set;
   logic            pin_evt, pin_active;
   logic [NV-1:0]   req, win;
   logic [3:0]      win_idx;
   logic            any_req, take;
   seq_state_t      state_ff;
   logic [PC_W-1:0] stack_ff [DEPTH];
   logic [SPW-1:0]  sp_ff;
   logic            irq_call_ff, ret_load_ff, wake_ff;
   logic [PC_W-1:0] vector_ff, ret_pc_ff;
   logic [31:0]     prdata_ff, rdata;
   logic            pend;

   // ************************************************************
   // APB decode
   // ************************************************************
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign we_core  = wr_en && (paddr == `VIC_OFF_CORE);
   assign we_tm0   = wr_en && (paddr == `VIC_OFF_TM0);
   assign we_ser   = wr_en && (paddr == `VIC_OFF_SERIAL);
   assign we_tba   = wr_en && (paddr == `VIC_OFF_TBADC);
   assign we_grp   = wr_en && (paddr == `VIC_OFF_GROUP);
   assign pend     = any_req & core_q[`VIC_BIT_EMI];

   // Read mux, unmapped addresses read zero
   always_comb begin
      rdata = 32'h0000_0000;
      hit   = 1'b1;
      case (paddr)
         `VIC_OFF_CORE:   rdata[7:0] = core_q;
         `VIC_OFF_TM0:    rdata[7:0] = tm0_q;
         `VIC_OFF_SERIAL: rdata[7:0] = ser_q;
         `VIC_OFF_TBADC:  rdata[7:0] = tba_q;
         `VIC_OFF_GROUP:  rdata[7:0] = grp_q;
         `VIC_OFF_EDGE:   rdata[1:0] = edge_ff;
         `VIC_OFF_STATUS: begin
            rdata[SPW-1:0]         = sp_ff;
            rdata[`VIC_STAT_PEND]  = pend;
         end
         default:         hit = 1'b0;
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_ff <= rdata;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // ************************************************************
   // Edge select and pin
   // ************************************************************
   // edge field write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_ff <= `VIC_EDGE_OFF;
      end else if (wr_en && (paddr == `VIC_OFF_EDGE)) begin
         edge_ff <= pwdata[1:0] & 2'(`VIC_MASK_EDGE);
      end
   end

   assign pin_active = core_q[`VIC_BIT_PIN_EN] & pin_dir_input;

   pin_edge_detect u_pin (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (pin_in),
      .active  (pin_active),
      .sel     (edge_ff),
      .evt     (pin_evt)
   );

   assign pin_pullup_en = pin_pullup_sel;

   // ************************************************************
   // Hardware set and clear strobes
   // ************************************************************
   // group flag on member rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_prev_ff <= 4'h0;
      end else begin
         grp_prev_ff <= grp_q[7:4];
      end
   end
   assign group_set = |(grp_q[7:4] & ~grp_prev_ff);

   assign core_set = {1'b0, protect_evt, touch_evt, pin_evt, 4'h0};
   assign tm0_set  = {tm0_evt, 4'h0};
   assign ser_set  = {uart_evt, eeprom_evt, sif_evt, group_set, 4'h0};
   assign tba_set  = {tb_evt[1], tb_evt[0], adc_evt, lowvolt_evt, 4'h0};
   assign grp_set  = {tm1_evt, 4'h0};

   assign core_clr = {1'b0, win[2], win[1], win[0], 3'h0, take};
   assign tm0_clr  = {win[6:3], 4'h0};
   assign ser_clr  = {win[9], win[8], win[7], win[10], 4'h0};
   assign tba_clr  = {win[14], win[13], win[12], win[11], 4'h0};

   // ************************************************************
   // Flag and enable registers
   // ************************************************************
   // flags held while blocked
   irq_flag_reg #(.MASK(`VIC_MASK_CORE), .RST(`VIC_RST_BYTE)) u_core (
      .pclk (pclk), .presetn (presetn), .we (we_core), .wdata (pwdata[7:0]),
      .set (core_set), .clr (core_clr), .q (core_q)
   );

   irq_flag_reg #(.MASK(`VIC_MASK_ALL), .RST(`VIC_RST_BYTE)) u_tm0 (
      .pclk (pclk), .presetn (presetn), .we (we_tm0), .wdata (pwdata[7:0]),
      .set (tm0_set), .clr (tm0_clr), .q (tm0_q)
   );

   irq_flag_reg #(.MASK(SER_MASK), .RST(`VIC_RST_BYTE)) u_ser (
      .pclk (pclk), .presetn (presetn), .we (we_ser), .wdata (pwdata[7:0]),
      .set (ser_set), .clr (ser_clr), .q (ser_q)
   );

   irq_flag_reg #(.MASK(`VIC_MASK_ALL), .RST(`VIC_RST_BYTE)) u_tba (
      .pclk (pclk), .presetn (presetn), .we (we_tba), .wdata (pwdata[7:0]),
      .set (tba_set), .clr (tba_clr), .q (tba_q)
   );

   irq_flag_reg #(.MASK(GRP_MASK), .RST(`VIC_RST_BYTE)) u_grp (
      .pclk (pclk), .presetn (presetn), .we (we_grp), .wdata (pwdata[7:0]),
      .set (grp_set), .clr (8'h00), .q (grp_q)
   );

   // ************************************************************
   // Request gating and priority
   // ************************************************************
   // flag and enable both needed
   assign req = {tba_q[7:4] & tba_q[3:0],
                 ser_q[4] & ser_q[0],
                 ser_q[7:5] & ser_q[3:1],
                 tm0_q[7:4] & tm0_q[3:0],
                 core_q[6:4] & core_q[3:1]};
   assign any_req = |req;

   always_comb begin
      win_idx = 4'h0;
      for (int i = NV - 1; i >= 0; i--) begin
         if (req[i]) begin
            win_idx = 4'(i);
         end
      end
   end

   assign take = (state_ff == ST_RUN) & core_boundary & core_q[`VIC_BIT_EMI]
               & any_req & ~stack_full & ~call_push & ~ret_pop;
   assign win  = take ? (NV'(1) << win_idx) : '0;

   // ************************************************************
   // Entry sequencer
   // ************************************************************
   // One cycle of entry per call, blocks a second take
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_RUN;
      end else begin
         case (state_ff)
            ST_RUN:   state_ff <= take ? ST_ENTER : ST_RUN;
            ST_ENTER: state_ff <= ST_RUN;
            default:  state_ff <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_call_ff <= 1'b0;
         vector_ff   <= '0;
      end else begin
         irq_call_ff <= take;
         if (take) begin
            vector_ff <= PC_W'(`VIC_VEC_BASE + 32'(win_idx) * `VIC_VEC_STEP);
         end
      end
   end

   // ************************************************************
   // Return stack
   // ************************************************************
   // push PC
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff       <= '0;
         ret_load_ff <= 1'b0;
         ret_pc_ff   <= '0;
      end else begin
         ret_load_ff <= 1'b0;
         if ((take | call_push) && !stack_full) begin
            sp_ff <= sp_ff + 1'b1;
         end else if (ret_pop && (sp_ff != '0)) begin
            sp_ff       <= sp_ff - 1'b1;
            ret_load_ff <= 1'b1;
            ret_pc_ff   <= stack_ff[IDXW'(sp_ff - 1'b1)];
         end
      end
   end

   // Stack storage, written at the pointer
   always_ff @(posedge pclk) begin
      if ((take | call_push) && !stack_full) begin
         stack_ff[IDXW'(sp_ff)] <= core_pc;
      end
   end

   assign stack_full = (sp_ff == SPW'(DEPTH));
   assign irq_call   = irq_call_ff;
   assign irq_vector = vector_ff;
   assign ret_load   = ret_load_ff;
   assign ret_pc     = ret_pc_ff;

   // ************************************************************
   // Wake-up
   // ************************************************************
   // only a fresh flag wakes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= sleep_mode & (|(core_set & ~core_q) | |(tm0_set & ~tm0_q)
                  | |(ser_set & ~ser_q & SER_MASK) | |(tba_set & ~tba_q)
                  | |(grp_set & ~grp_q & GRP_MASK));
      end
   end
   assign wake_req = wake_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   call_needs_emi_a: assert property (
      irq_call_ff |-> $past(core_q[`VIC_BIT_EMI])) else $error("call taken with global enable low");
   emi_cleared_a: assert property (
      irq_call_ff && !$past(we_core) |-> !core_q[`VIC_BIT_EMI]) else $error("global enable not cleared on entry");
   full_blocks_a: assert property (
      stack_full && !ret_pop |=> !irq_call_ff) else $error("call taken with full stack");
   pc_pushed_a: assert property (
      irq_call_ff |-> stack_ff[IDXW'(sp_ff - 1'b1)] == $past(core_pc)
                      && sp_ff == $past(sp_ff) + 1'b1) else $error("PC not pushed on entry");
   pc_popped_a: assert property (
      ret_load_ff |-> ret_pc_ff == stack_ff[IDXW'(sp_ff)]) else $error("return PC wrong");
   flag_held_a: assert property (
      tm0_evt[0] && !core_q[`VIC_BIT_EMI] |=> tm0_q[4] [*2]) else $error("blocked request lost");
   pin_edge_a: assert property (
      pin_evt |=> core_q[`VIC_BIT_PIN_FLAG]) else $error("pin edge did not set flag");
   top_priority_a: assert property (
      take && req[0] |=> irq_vector == PC_W'(`VIC_VEC_BASE) && !core_q[4]) else $error("pin request not served first");
   group_rise_a: assert property (
      ($rose(grp_q[7]) || $rose(grp_q[4])) && SER_MASK[4] |=> ser_q[`VIC_BIT_GRP_FLAG])
      else $error("group flag not set by member");
   fresh_wake_a: assert property (
      sleep_mode && adc_evt && !tba_q[5] |=> wake_req) else $error("new flag did not wake");
endmodule

`default_nettype wire

// File: src/vic_defines.svh
/*
 * Register offsets, field positions, reset values, implemented-bit masks
 * and vector layout of the vectored interrupt controller.
 * Assumes an 8-bit APB byte address with one 32-bit word per register.
 */
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define VIC_OFF_CORE     8'h00
`define VIC_OFF_TM0      8'h04
`define VIC_OFF_SERIAL   8'h08
`define VIC_OFF_TBADC    8'h0c
`define VIC_OFF_GROUP    8'h10
`define VIC_OFF_EDGE     8'h14
`define VIC_OFF_STATUS   8'h18

// ************************************************************
// Reset values and implemented bits
// ************************************************************
`define VIC_RST_BYTE     8'h00
`define VIC_MASK_ALL     8'hff
`define VIC_MASK_CORE    8'h7f
`define VIC_MASK_SER_SM  8'hee
`define VIC_MASK_GRP_SM  8'h00
`define VIC_MASK_GRP_MID 8'h33
`define VIC_MASK_EDGE    8'h03

// ************************************************************
// Field positions
// ************************************************************
`define VIC_BIT_EMI      0
`define VIC_BIT_PIN_EN   1
`define VIC_BIT_PIN_FLAG 4
`define VIC_BIT_GRP_FLAG 4
`define VIC_STAT_PEND    8

// ************************************************************
// Edge select codes and vector layout
// ************************************************************
`define VIC_EDGE_OFF     2'h0
`define VIC_EDGE_RISE    2'h1
`define VIC_EDGE_FALL    2'h2
`define VIC_EDGE_BOTH    2'h3
`define VIC_VEC_BASE     4
`define VIC_VEC_STEP     4
`define VIC_NUM_VEC      15
`define VIC_STACK_DEPTH  8

`endif

// File: src/vic_pkg.sv
/*
 * Types shared by the interrupt controller modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package vic_pkg;
   // Entry sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_ENTER = 2'b10
   } seq_state_t;

   // Device size variants
   typedef enum logic [1:0] {
      VAR_SMALL = 2'h0,
      VAR_MID   = 2'h1,
      VAR_FULL  = 2'h2
   } variant_t;
endpackage

`default_nettype wire
